// [dv/rgs_host_model.sv]
// Host model that fetches words from the generator by polling its status.
`timescale 1ns/1ps
module rgs_host_model (
   input wire logic clk,
   input wire logic want_word,
   input wire logic [31:0] generator_status,
   output logic output_rd
);
   import rgs_pkg::*;
   initial output_rd = 1'b0;
   // Reads only when a word is held, so the model never causes an underflow.
   // The oscillator flag is never looked at, since it is not deterministic.
   always @(negedge clk) begin
      output_rd <= want_word && !output_rd && (generator_status[RGS_FILL_MSB:RGS_FILL_LSB] == RGS_FILL_ONE);
   end
endmodule // rgs_host_model

// [dv/rgs_status_tb.sv]
// Self-checking testbench of the generator status block.
`timescale 1ns/1ps
module rgs_status_tb;
   import rgs_pkg::*;
   localparam logic [31:0] BASE = {8'h00, RGS_OUTPUT_CAPACITY, 16'h0000};
   logic clk = 1'b0, nrst = 1'b0, sleep_request = 1'b0, load_enable_set = 1'b0, high_assurance_set = 1'b0;
   logic clear_interrupt_request = 1'b0, interrupt_mask_bit = 1'b0, control_rd = 1'b0, status_wr = 1'b0;
   logic bench_rd = 1'b0, entropy_wr = 1'b0, want_word = 1'b0, osc_stop, error_irq, host_rd, ce = 1'b1;
   logic [31:0] first_word;
   logic [31:0] status_wr_data = 32'h0000_0000, entropy_data = 32'h0000_0000, generator_status, random_output_buffer;
   wire logic output_rd = bench_rd | host_rd;
   // The oscillator flag is masked because its value is not deterministic.
   wire logic [31:0] st = generator_status & 32'h7FFF_FFFF;
   int mismatches = 0, n_compared = 0, n;
   always #20 clk = ~clk;
   rgs_status i_dut (.clk(clk), .nrst(nrst), .ce(ce), .sleep_request(sleep_request),
      .load_enable_set(load_enable_set), .high_assurance_set(high_assurance_set),
      .clear_interrupt_request(clear_interrupt_request), .interrupt_mask_bit(interrupt_mask_bit),
      .control_rd(control_rd), .status_wr(status_wr), .status_wr_data(status_wr_data), .output_rd(output_rd),
      .entropy_wr(entropy_wr), .entropy_data(entropy_data), .generator_status(generator_status),
      .random_output_buffer(random_output_buffer), .osc_stop(osc_stop), .error_irq(error_irq));
   rgs_host_model i_host (.clk(clk), .want_word(want_word), .generator_status(generator_status), .output_rd(host_rd));
   task automatic step(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle strobe: 0 output read, 1 control read, 2 clear interrupt, 3 high assurance, 4 load enable.
   task automatic set_strobe(input int k, input logic v);
      case (k)
         0: bench_rd = v;
         1: control_rd = v;
         2: clear_interrupt_request = v;
         3: high_assurance_set = v;
         default: load_enable_set = v;
      endcase
   endtask
   // Only the strobe that was raised is lowered, so back-to-back pulses never touch one signal twice.
   task automatic pulse(input int k);
      set_strobe(k, 1'b1);
      step(1);
      set_strobe(k, 1'b0);
   endtask
   // Bounded wait for a held word; the wait length is returned.
   task automatic wait_fill(output int w);
      w = 0;
      while (st[RGS_FILL_MSB:RGS_FILL_LSB] !== RGS_FILL_ONE && w < 600) begin
         step(1);
         w++;
      end
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      step(4);
      nrst = 1'b1;
      step(1);
      check(st, BASE);
      status_wr = 1'b1;
      status_wr_data = 32'hFFFF_FFFF;
      entropy_wr = 1'b1;
      entropy_data = 32'h5A5A_1234;
      step(1);
      {status_wr, entropy_wr} = 2'h0;
      step(1);
      check(st, BASE);
      // An empty read while the clock enable is low must leave every flag alone.
      ce = 1'b0;
      pulse(0);
      check(st, BASE);
      ce = 1'b1;
      step(1);
      interrupt_mask_bit = 1'b1;
      pulse(0);
      check(st, BASE | 32'h0000_000E);
      check({31'h0, error_irq}, 32'h0);
      pulse(1);
      check(st, BASE | 32'h0000_000A);
      pulse(2);
      check(st, BASE | 32'h0000_0002);
      interrupt_mask_bit = 1'b0;
      pulse(3);
      pulse(0);
      check(st, BASE | 32'h0000_000F);
      check({31'h0, error_irq}, 32'h1);
      interrupt_mask_bit = 1'b1;
      step(1);
      pulse(0);
      check(st, BASE | 32'h0000_000F);
      check({31'h0, error_irq}, 32'h1);
      interrupt_mask_bit = 1'b0;
      pulse(2);
      pulse(1);
      check(st, BASE | 32'h0000_0003);
      check({31'h0, error_irq}, 32'h0);
      pulse(4);
      want_word = 1'b1;
      wait_fill(n);
      check({24'h0, st[RGS_FILL_MSB:RGS_FILL_LSB]}, {24'h0, RGS_FILL_ONE});
      check(32'(n), RGS_LOAD_PERIOD_CYC);
      first_word = random_output_buffer;
      step(1);
      check(st, BASE | 32'h0000_0001);
      wait_fill(n);
      check(32'(n + 1), RGS_LOAD_PERIOD_CYC);
      check({31'h0, random_output_buffer !== first_word}, 32'h1);
      step(1);
      // Sleep and then reset walk the stop-and-clear part of the oscillator check; the flag stays masked.
      sleep_request = 1'b1;
      step(1);
      check(st & 32'h0000_FF10, 32'h0000_0010);
      check({31'h0, osc_stop}, 32'h1);
      step(300);
      check(st & 32'h0000_FF10, 32'h0000_0010);
      sleep_request = 1'b0;
      wait_fill(n);
      check({24'h0, st[RGS_FILL_MSB:RGS_FILL_LSB]}, {24'h0, RGS_FILL_ONE});
      want_word = 1'b0;
      nrst = 1'b0;
      step(2);
      nrst = 1'b1;
      step(1);
      check(st, BASE);
      check(random_output_buffer, RGS_WORD_ZERO);
      pulse(0);
      check(st, BASE | 32'h0000_000E);
      report_and_stop();
   end
endmodule // rgs_status_tb

// [hdl/rgs_core.sv]
// Word source that stands in for the shift-register engine of the generator.
`timescale 1ns/1ps
module rgs_core (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic run,
   input wire logic [31:0] entropy_data,
   input wire logic entropy_wr,
   output logic [31:0] word,
   output logic stuck
);
   import rgs_pkg::*;
   typedef struct packed {
      logic [31:0] lfsr;
   } rgs_core_state_type;
   rgs_core_state_type state_reg, state_next;

   always_comb begin
      state_next = state_reg;
      if (run) begin
         state_next.lfsr = {state_reg.lfsr[30:0], ^(state_reg.lfsr & RGS_LFSR_TAPS)};
      end
      if (entropy_wr) begin
         state_next.lfsr = state_next.lfsr ^ entropy_data;
      end
      if (state_next.lfsr == RGS_WORD_ZERO) begin
         state_next.lfsr = RGS_LFSR_SEED;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= '{lfsr: RGS_LFSR_SEED};
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign word = state_reg.lfsr;
   // The register still holding its seed counts as stuck in its reset state.
   assign stuck = (state_reg.lfsr == RGS_LFSR_SEED);
endmodule // rgs_core

// [hdl/rgs_pkg.sv]
// Package with constants for the random generator status block.
package rgs_pkg;
   localparam int unsigned RGS_CLK_HZ = 25000000;
   localparam int unsigned RGS_LOAD_PERIOD_CYC = 256;
   localparam logic [7:0] RGS_LOAD_LAST = 8'hFF;
   localparam logic [7:0] RGS_OUTPUT_CAPACITY = 8'h01;
   localparam logic [7:0] RGS_FILL_ONE = 8'h01;
   localparam logic [7:0] RGS_FILL_ZERO = 8'h00;
   localparam int unsigned RGS_OSC_FAIL_BIT = 31;
   localparam int unsigned RGS_CAP_MSB = 23;
   localparam int unsigned RGS_CAP_LSB = 16;
   localparam int unsigned RGS_FILL_MSB = 15;
   localparam int unsigned RGS_FILL_LSB = 8;
   localparam int unsigned RGS_SLEEP_BIT = 4;
   localparam int unsigned RGS_ERR_BIT = 3;
   localparam int unsigned RGS_UNDER_BIT = 2;
   localparam int unsigned RGS_LAST_BIT = 1;
   localparam int unsigned RGS_SV_BIT = 0;
   localparam logic [31:0] RGS_LFSR_SEED = 32'h00000001;
   localparam logic [31:0] RGS_LFSR_TAPS = 32'h80200003;
   localparam logic [31:0] RGS_WORD_ZERO = 32'h00000000;
endpackage

// [hdl/rgs_status.sv]
// Status register and output-buffer bookkeeping of the random generator.
// Overview of operation
// - Bit 31 set while shift register stuck.
// - Bits 23-16 report buffer capacity one.
// - Bits 15-8 report buffer fill, max one.
// - Bit 4 mirrors sleep; no loads then.
// - Bit 3 error on empty read, clear-interrupt clears.
// - Bit 2 underflow, cleared by control read.
// - Bit 1 reflects latest output read result.
// - Bit 0 security violation, reset-only clear.
// - Status register ignores all writes.
// - Load word every 256 cycles after enable.
// - High-assurance sticky until hardware reset.
`timescale 1ns/1ps
module rgs_status (
   clk,
   nrst,
   ce,
   sleep_request,
   load_enable_set,
   high_assurance_set,
   clear_interrupt_request,
   interrupt_mask_bit,
   control_rd,
   status_wr,
   status_wr_data,
   output_rd,
   entropy_wr,
   entropy_data,
   generator_status,
   random_output_buffer,
   osc_stop,
   error_irq
);
   import rgs_pkg::*;
   input wire logic clk;
   input wire logic nrst;
   input wire logic ce;
   input wire logic sleep_request;
   input wire logic load_enable_set;
   input wire logic high_assurance_set;
   input wire logic clear_interrupt_request;
   input wire logic interrupt_mask_bit;
   input wire logic control_rd;
   input wire logic status_wr;
   input wire logic [31:0] status_wr_data;
   input wire logic output_rd;
   input wire logic entropy_wr;
   input wire logic [31:0] entropy_data;
   output logic [31:0] generator_status;
   output logic [31:0] random_output_buffer;
   output logic osc_stop;
   output logic error_irq;

   typedef enum logic [0:0] {RGS_IDLE, RGS_LOADING} rgs_mode_type;
   typedef struct packed {
      rgs_mode_type mode;
      logic [7:0] cnt;
      logic [31:0] buffer;
      logic full;
      logic sleep;
      logic ha;
      logic err;
      logic under;
      logic last_empty;
      logic sv;
      logic stuck;
      logic irq;
   } rgs_state_type;
   rgs_state_type state_reg, state_next;

   logic [31:0] core_word;
   logic core_stuck;
   logic load_now;
   logic underflow;

   function automatic logic [7:0] rgs_level(input logic full);
      rgs_level = full ? RGS_FILL_ONE : RGS_FILL_ZERO;
   endfunction

   rgs_core u_core (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .run(!state_reg.sleep),
      .entropy_data(entropy_data),
      .entropy_wr(entropy_wr),
      .word(core_word),
      .stuck(core_stuck)
   );

   assign underflow = output_rd && !state_reg.full;
   assign load_now = (state_reg.mode == RGS_LOADING) && !state_reg.sleep && (state_reg.cnt == RGS_LOAD_LAST);

   always_comb begin
      state_next = state_reg;
      state_next.sleep = sleep_request;
      state_next.stuck = core_stuck;
      if (high_assurance_set) begin
         state_next.ha = 1'b1;
      end
      case (state_reg.mode)
         RGS_IDLE: begin
            if (load_enable_set) begin
               state_next.mode = RGS_LOADING;
               state_next.cnt = '0;
            end
         end
         RGS_LOADING: begin
            if (!state_reg.sleep) begin
               state_next.cnt = state_reg.cnt + 8'h01;
            end
         end
         default: state_next.mode = RGS_IDLE;
      endcase
      // A read and a load in one cycle leave the fresh word in place.
      if (output_rd) begin
         state_next.full = 1'b0;
         state_next.last_empty = !state_reg.full;
      end
      if (load_now) begin
         state_next.buffer = core_word;
         state_next.full = 1'b1;
      end
      if (clear_interrupt_request) begin
         state_next.err = 1'b0;
         state_next.irq = 1'b0;
      end
      if (control_rd) begin
         state_next.under = 1'b0;
      end
      // Set wins over a clear arriving in the same cycle.
      if (underflow) begin
         state_next.err = 1'b1;
         state_next.under = 1'b1;
         // A masked underflow leaves an interrupt that is already pending as it was.
         if (!interrupt_mask_bit) begin
            state_next.irq = 1'b1;
         end
         if (state_reg.ha) begin
            state_next.sv = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= '{mode: RGS_IDLE, cnt: '0, buffer: RGS_WORD_ZERO, default: 1'b0};
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // Writes to the status register are never decoded here, so no field can change.
   always_comb begin
      generator_status = RGS_WORD_ZERO;
      generator_status[RGS_OSC_FAIL_BIT] = state_reg.stuck;
      generator_status[RGS_CAP_MSB:RGS_CAP_LSB] = RGS_OUTPUT_CAPACITY;
      generator_status[RGS_FILL_MSB:RGS_FILL_LSB] = rgs_level(state_reg.full);
      generator_status[RGS_SLEEP_BIT] = state_reg.sleep;
      generator_status[RGS_ERR_BIT] = state_reg.err;
      generator_status[RGS_UNDER_BIT] = state_reg.under;
      generator_status[RGS_LAST_BIT] = state_reg.last_empty;
      generator_status[RGS_SV_BIT] = state_reg.sv;
   end
   assign random_output_buffer = state_reg.buffer;
   assign osc_stop = state_reg.sleep;
   assign error_irq = state_reg.irq;

   a_fill_rises_load: assert property (@(posedge clk) disable iff (!nrst)
      ce && load_now |=> generator_status[RGS_FILL_MSB:RGS_FILL_LSB] == RGS_FILL_ONE)
      else $error("fill did not rise after load");
   a_err_on_underflow: assert property (@(posedge clk) disable iff (!nrst)
      ce && underflow |=> state_reg.err && state_reg.under && state_reg.last_empty)
      else $error("underflow flags not set");
   a_under_ctrl_clear: assert property (@(posedge clk) disable iff (!nrst)
      ce && control_rd && !underflow |=> !state_reg.under)
      else $error("underflow flag not cleared by control read");
   a_last_read_ok: assert property (@(posedge clk) disable iff (!nrst)
      ce && output_rd && state_reg.full |=> !state_reg.last_empty)
      else $error("last read flag wrong");
   a_sv_sticky: assert property (@(posedge clk) disable iff (!nrst)
      state_reg.sv |=> state_reg.sv)
      else $error("security flag dropped");
   a_sv_needs_ha: assert property (@(posedge clk) disable iff (!nrst)
      $rose(state_reg.sv) |-> $past(state_reg.ha))
      else $error("security flag without high assurance");
   a_ha_sticky: assert property (@(posedge clk) disable iff (!nrst)
      state_reg.ha |=> state_reg.ha)
      else $error("high assurance dropped");
   a_cap_fixed: assert property (@(posedge clk) disable iff (!nrst)
      generator_status[RGS_CAP_MSB:RGS_CAP_LSB] == RGS_OUTPUT_CAPACITY
      && generator_status[RGS_FILL_MSB:RGS_FILL_LSB] <= RGS_FILL_ONE)
      else $error("capacity or level out of range");
   a_sleep_no_load: assert property (@(posedge clk) disable iff (!nrst)
      ce && state_reg.sleep && !state_reg.full |=> !state_reg.full)
      else $error("buffer loaded in sleep");
   a_load_period: assert property (@(posedge clk) disable iff (!nrst)
      ce && load_now ##1 ce [*8] |-> !load_now)
      else $error("loads too close together");
   a_err_ci_clear: assert property (@(posedge clk) disable iff (!nrst)
      ce && clear_interrupt_request && !underflow |=> !state_reg.err)
      else $error("error flag not cleared");
   a_irq_on_underflow: assert property (@(posedge clk) disable iff (!nrst)
      ce && underflow && !interrupt_mask_bit |=> error_irq)
      else $error("interrupt not raised on unmasked underflow");
   a_irq_kept_pending: assert property (@(posedge clk) disable iff (!nrst)
      ce && error_irq && !clear_interrupt_request |=> error_irq)
      else $error("interrupt dropped without clear request");
   a_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
      !ce |=> $stable(state_reg))
      else $error("state moved while clock enable low");

   c_load: cover property (@(posedge clk) load_now);
   c_frozen_read: cover property (@(posedge clk) !ce && output_rd);
   c_underflow: cover property (@(posedge clk) underflow && state_reg.ha);
   c_good_read: cover property (@(posedge clk) output_rd && state_reg.full);
   c_sleep_hold: cover property (@(posedge clk) state_reg.sleep && state_reg.mode == RGS_LOADING);
endmodule // rgs_status
